/* File: hdl/rpg_pkg.sv */
/*
  package for the rail power-good and general input function block:
  sizes, register offsets, field positions and reset values.
  assumes an apb slave with 32-bit data and one word per register.
*/
package rpg_pkg;
  localparam int NUM_RAILS = 24;
  localparam int NUM_INPUTS = 24;
  localparam int ADC_W = 12;
  localparam int RAIL_IDX_W = 5;

  // on/off source encodings
  typedef enum logic [1:0] {
    RPG_SRC_AUTO = 2'h0,
    RPG_SRC_CTRL = 2'h1,
    RPG_SRC_OPER = 2'h2,
    RPG_SRC_BOTH = 2'h3
  } rpg_src_t;

  // margin state encodings
  localparam logic [1:0] MARGIN_NONE = 2'h0;
  localparam logic [1:0] MARGIN_LOW  = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;

  // register byte offsets
  localparam logic [11:0] OFS_RAIL_SEL    = 12'h000;
  localparam logic [11:0] OFS_PG_ON_THR   = 12'h004;
  localparam logic [11:0] OFS_PG_OFF_THR  = 12'h008;
  localparam logic [11:0] OFS_RAIL_CFG    = 12'h00c;
  localparam logic [11:0] OFS_OPER        = 12'h010;
  localparam logic [11:0] OFS_IN_EN       = 12'h014;
  localparam logic [11:0] OFS_IN_POL      = 12'h018;
  localparam logic [11:0] OFS_IN_FAULT_EN = 12'h01c;
  localparam logic [11:0] OFS_IN_CLR_EN   = 12'h020;
  localparam logic [11:0] OFS_MARGIN_SRC  = 12'h024;
  localparam logic [11:0] OFS_PG_STAT     = 12'h028;
  localparam logic [11:0] OFS_IN_STAT     = 12'h02c;
  localparam logic [11:0] OFS_UV_MASK     = 12'h030;
  localparam logic [11:0] OFS_MISC_STAT   = 12'h034;
  localparam logic [11:0] OFS_MARGIN_EN   = 12'h038;

  // rail_cfg fields
  localparam int CFG_MON_BIT  = 0;
  localparam int CFG_VIN_BIT  = 1;
  localparam int CFG_SRC_LSB  = 2;
  // margin_src fields: enable index, valid, select index, valid
  localparam int MSRC_EN_LSB  = 0;
  localparam int MSRC_EN_VLD  = 5;
  localparam int MSRC_SEL_LSB = 8;
  localparam int MSRC_SEL_VLD = 13;
  // misc_stat fields
  localparam int MISC_VIN_LOW  = 0;
  localparam int MISC_REJECT   = 1;
  localparam int MISC_FAULT    = 2;
  localparam int MISC_MEN      = 3;
  localparam int MISC_MLOW     = 4;
  localparam int MISC_SS_LSB   = 8;

  localparam logic [ADC_W-1:0] PG_ON_RST  = 12'hfff;
  localparam logic [ADC_W-1:0] PG_OFF_RST = 12'h000;
endpackage

/* File: hdl/rpg_top.sv */
/*
  rail power-good status and general input function logic.
  holds per-rail hysteretic power-good and under-voltage suppression,
  and per-input polarity with fault, latched-clear and
  margin roles. assumes adc samples, eligibility flags and pins are
  synchronous to mclk, and an apb master in the mclk domain.
*/
`timescale 1ns/100ps
module rpg_top
  import rpg_pkg::*;
(
  input  wire logic                              mclk,             // system clock
  input  wire logic                              rst_n,            // sync reset, active low
  input  wire logic [11:0]                       paddr,            // apb address
  input  wire logic                              psel,             // apb select
  input  wire logic                              penable,          // apb enable
  input  wire logic                              pwrite,           // apb direction
  input  wire logic [31:0]                       pwdata,           // apb write data
  output logic      [31:0]                       prdata,           // apb read data
  output logic                                   pready,           // apb ready
  output logic                                   pslverr,          // apb error
  input  wire logic [rpg_pkg::NUM_INPUTS-1:0]    gpio_in,          // raw pin levels
  input  wire logic [rpg_pkg::NUM_RAILS*rpg_pkg::ADC_W-1:0] rail_volt, // monitor samples
  input  wire logic [rpg_pkg::NUM_RAILS-1:0]     rail_sample_vld,  // sample strobe per rail
  input  wire logic [rpg_pkg::NUM_RAILS-1:0]     on_eligible,      // turn-on conditions met
  input  wire logic [rpg_pkg::NUM_RAILS-1:0]     off_eligible,     // turn-off conditions met
  input  wire logic [rpg_pkg::NUM_RAILS-1:0]     fault_off,        // fault response turned rail off
  input  wire logic                              control_line,     // control line asserted
  input  wire logic [rpg_pkg::NUM_RAILS-1:0]     uv_raw,           // raw under-voltage events
  output logic      [rpg_pkg::NUM_RAILS-1:0]     power_good,       // per-rail power-good
  output logic      [rpg_pkg::NUM_RAILS-1:0]     uv_event,         // unsuppressed under-voltage
  output logic      [rpg_pkg::NUM_RAILS-1:0]     seek_on,          // rail on/off request
  output logic      [rpg_pkg::NUM_INPUTS-1:0]    input_asserted,   // dependency/cascade source
  output logic      [2:0]                        state_select,     // pin-selected state code
  output logic                                   input_fault,      // fault event pulse
  output logic                                   latch_clear,      // latched status clear, level while input asserted
  output logic      [rpg_pkg::NUM_RAILS*2-1:0]   margin_state      // per-rail margin state
);
  import rpg_pkg::*;

  logic [RAIL_IDX_W-1:0]    sel_reg;
  logic [ADC_W-1:0]         pg_on_reg  [NUM_RAILS];
  logic [ADC_W-1:0]         pg_off_reg [NUM_RAILS];
  logic [3:0]               cfg_reg    [NUM_RAILS];
  logic [NUM_RAILS-1:0]     oper_reg;
  logic [NUM_INPUTS-1:0]    in_en_reg;
  logic [NUM_INPUTS-1:0]    in_pol_reg;
  logic [NUM_INPUTS-1:0]    in_fault_en_reg;
  logic [NUM_INPUTS-1:0]    in_clr_en_reg;
  logic [NUM_RAILS-1:0]     margin_en_reg;
  logic [RAIL_IDX_W-1:0]    men_idx_reg;
  logic                     men_vld_reg;
  logic [RAIL_IDX_W-1:0]    msel_idx_reg;
  logic                     msel_vld_reg;
  logic                     reject_reg;
  logic [NUM_RAILS-1:0]     seen_pg_reg;
  logic [NUM_INPUTS-1:0]    asserted_prev_reg;
  logic                     vin_low_reg;
  logic [NUM_INPUTS-1:0]    asserted_next;
  logic [NUM_RAILS-1:0]     pg_next;
  logic [NUM_RAILS-1:0]     vin_low_vec;
  logic                     men_next;
  logic                     mlow_next;
  logic [2:0]               ss_next;
  logic                     wr_en;
  logic                     rd_en;
  logic [31:0]              rd_data;
  logic                     rd_err;

  function automatic logic [ADC_W-1:0] volt_of(input logic [NUM_RAILS*ADC_W-1:0] v, input int i);
    volt_of = v[i*ADC_W +: ADC_W];
  endfunction

  // first three enabled inputs, lowest index first
  function automatic logic [2:0] pick_state(input logic [NUM_INPUTS-1:0] en,
                                            input logic [NUM_INPUTS-1:0] a);
    logic [1:0] n;
    logic [2:0] r;
    n = 2'h0;
    r = 3'h0;
    for (int k = 0; k < NUM_INPUTS; k++) begin
      if (en[k] && n != 2'h3) begin
        r[n] = a[k];
        n = n + 2'h1;
      end
    end
    pick_state = r;
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // polarity applied once; all roles read asserted_next
  always_comb begin
    asserted_next = in_en_reg & (gpio_in ^ in_pol_reg);
  end

  // hysteretic or eligibility-based power-good
  always_comb begin
    for (int i = 0; i < NUM_RAILS; i++) begin
      pg_next[i] = power_good[i];
      if (cfg_reg[i][CFG_MON_BIT]) begin
        if (rail_sample_vld[i]) begin
          if (volt_of(rail_volt, i) > pg_on_reg[i])
            pg_next[i] = 1'b1;
          else if (volt_of(rail_volt, i) < pg_off_reg[i])
            pg_next[i] = 1'b0;
        end
      end else begin
        // no enable pin is consulted here
        if (on_eligible[i])
          pg_next[i] = 1'b1;
        else if (off_eligible[i])
          pg_next[i] = 1'b0;
      end
      if (fault_off[i])
        pg_next[i] = 1'b0;
      vin_low_vec[i] = cfg_reg[i][CFG_VIN_BIT] && power_good[i] == 1'b0 && seen_pg_reg[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power_good  <= '0;
      seen_pg_reg <= '0;
    end else begin
      power_good  <= pg_next;
      seen_pg_reg <= seen_pg_reg | pg_next;
    end
  end

  // vin monitor dropped below off threshold after having been good
  always_ff @(posedge mclk) begin
    if (!rst_n)
      vin_low_reg <= 1'b0;
    else
      vin_low_reg <= |vin_low_vec;
  end

  // under-voltage suppression
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      uv_event <= '0;
    end else begin
      for (int i = 0; i < NUM_RAILS; i++)
        uv_event[i] <= uv_raw[i] && seek_on[i]
                       && seen_pg_reg[i]
                       && !(vin_low_reg && !cfg_reg[i][CFG_VIN_BIT]);
    end
  end

  // on/off source per rail
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seek_on <= '0;
    end else begin
      for (int i = 0; i < NUM_RAILS; i++) begin
        case (rpg_src_t'(cfg_reg[i][CFG_SRC_LSB +: 2]))
          RPG_SRC_AUTO: seek_on[i] <= 1'b1;
          RPG_SRC_CTRL: seek_on[i] <= control_line;
          RPG_SRC_OPER: seek_on[i] <= oper_reg[i];
          RPG_SRC_BOTH: seek_on[i] <= control_line && oper_reg[i];
          default:      seek_on[i] <= 1'b0;
        endcase
      end
    end
  end

  // input roles
  always_comb begin
    men_next  = men_vld_reg && asserted_next[men_idx_reg];
    mlow_next = msel_vld_reg && asserted_next[msel_idx_reg];
    ss_next   = pick_state(in_en_reg, asserted_next);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      asserted_prev_reg <= '0;
      input_asserted    <= '0;
      state_select      <= '0;
      input_fault       <= 1'b0;
      latch_clear       <= 1'b0;
    end else begin
      asserted_prev_reg <= asserted_next;
      input_asserted    <= asserted_next;
      state_select      <= ss_next;
      // the fault role on a state-select input is not blocked here
      input_fault       <= |(in_fault_en_reg & asserted_prev_reg & ~asserted_next);
      latch_clear       <= |(in_clr_en_reg & asserted_next);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      margin_state <= '0;
    end else begin
      for (int i = 0; i < NUM_RAILS; i++) begin
        if (men_next && margin_en_reg[i])
          margin_state[i*2 +: 2] <= mlow_next ? MARGIN_LOW : MARGIN_HIGH;
        else
          margin_state[i*2 +: 2] <= MARGIN_NONE;
      end
    end
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_reg         <= '0;
      oper_reg        <= '0;
      in_en_reg       <= '0;
      in_pol_reg      <= '0;
      in_fault_en_reg <= '0;
      in_clr_en_reg   <= '0;
      margin_en_reg   <= '0;
      men_idx_reg     <= '0;
      men_vld_reg     <= 1'b0;
      msel_idx_reg    <= '0;
      msel_vld_reg    <= 1'b0;
      reject_reg      <= 1'b0;
      for (int i = 0; i < NUM_RAILS; i++) begin
        pg_on_reg[i]  <= PG_ON_RST;
        pg_off_reg[i] <= PG_OFF_RST;
        cfg_reg[i]    <= '0;
      end
    end else if (wr_en) begin
      case (paddr)
        OFS_RAIL_SEL:    sel_reg <= pwdata[RAIL_IDX_W-1:0];
        OFS_PG_ON_THR:   pg_on_reg[sel_reg] <= pwdata[ADC_W-1:0];
        OFS_PG_OFF_THR:  pg_off_reg[sel_reg] <= pwdata[ADC_W-1:0];
        OFS_RAIL_CFG:    cfg_reg[sel_reg] <= pwdata[3:0];
        OFS_OPER:        oper_reg <= pwdata[NUM_RAILS-1:0];
        OFS_IN_EN:       in_en_reg <= pwdata[NUM_INPUTS-1:0];
        OFS_IN_POL:      in_pol_reg <= pwdata[NUM_INPUTS-1:0];
        OFS_IN_FAULT_EN: in_fault_en_reg <= pwdata[NUM_INPUTS-1:0];
        OFS_IN_CLR_EN:   in_clr_en_reg <= pwdata[NUM_INPUTS-1:0];
        OFS_MARGIN_EN:   margin_en_reg <= pwdata[NUM_RAILS-1:0];
        OFS_MARGIN_SRC: begin
          // a second holder is refused until the role is released
          if (pwdata[MSRC_EN_VLD] && men_vld_reg &&
              pwdata[MSRC_EN_LSB +: RAIL_IDX_W] != men_idx_reg) begin
            reject_reg <= 1'b1;
          end else begin
            men_vld_reg <= pwdata[MSRC_EN_VLD];
            men_idx_reg <= pwdata[MSRC_EN_LSB +: RAIL_IDX_W];
          end
          if (pwdata[MSRC_SEL_VLD] && msel_vld_reg &&
              pwdata[MSRC_SEL_LSB +: RAIL_IDX_W] != msel_idx_reg) begin
            reject_reg <= 1'b1;
          end else begin
            msel_vld_reg <= pwdata[MSRC_SEL_VLD];
            msel_idx_reg <= pwdata[MSRC_SEL_LSB +: RAIL_IDX_W];
          end
        end
        OFS_MISC_STAT:   reject_reg <= reject_reg & ~pwdata[MISC_REJECT];
        default: ;
      endcase
    end
  end

  // read mux, decoded in setup so the data is ready in the access cycle
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    case (paddr)
      OFS_RAIL_SEL:    rd_data[RAIL_IDX_W-1:0] = sel_reg;
      OFS_PG_ON_THR:   rd_data[ADC_W-1:0] = pg_on_reg[sel_reg];
      OFS_PG_OFF_THR:  rd_data[ADC_W-1:0] = pg_off_reg[sel_reg];
      OFS_RAIL_CFG:    rd_data[3:0] = cfg_reg[sel_reg];
      OFS_OPER:        rd_data[NUM_RAILS-1:0] = oper_reg;
      OFS_IN_EN:       rd_data[NUM_INPUTS-1:0] = in_en_reg;
      OFS_IN_POL:      rd_data[NUM_INPUTS-1:0] = in_pol_reg;
      OFS_IN_FAULT_EN: rd_data[NUM_INPUTS-1:0] = in_fault_en_reg;
      OFS_IN_CLR_EN:   rd_data[NUM_INPUTS-1:0] = in_clr_en_reg;
      OFS_MARGIN_EN:   rd_data[NUM_RAILS-1:0] = margin_en_reg;
      OFS_MARGIN_SRC: begin
        rd_data[MSRC_EN_LSB +: RAIL_IDX_W]  = men_idx_reg;
        rd_data[MSRC_EN_VLD]                = men_vld_reg;
        rd_data[MSRC_SEL_LSB +: RAIL_IDX_W] = msel_idx_reg;
        rd_data[MSRC_SEL_VLD]               = msel_vld_reg;
      end
      OFS_PG_STAT:     rd_data[NUM_RAILS-1:0] = power_good;
      OFS_IN_STAT:     rd_data[NUM_INPUTS-1:0] = input_asserted;
      OFS_UV_MASK:     rd_data[NUM_RAILS-1:0] = seen_pg_reg;
      OFS_MISC_STAT: begin
        rd_data[MISC_VIN_LOW] = vin_low_reg;
        rd_data[MISC_REJECT]  = reject_reg;
        rd_data[MISC_FAULT]   = input_fault;
        rd_data[MISC_MEN]     = men_next;
        rd_data[MISC_MLOW]    = mlow_next;
        rd_data[MISC_SS_LSB +: 3] = state_select;
      end
      default:         rd_err = 1'b1;
    endcase
  end

  // one wait-free access: pready in the access cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      if (rd_en)
        prdata <= rd_data;
    end
  end

  pg_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_reg[0][CFG_MON_BIT] && rail_sample_vld[0] && !fault_off[0] &&
    volt_of(rail_volt, 0) > pg_on_reg[0] |=> power_good[0])
    else $error("power-good not set above on threshold");

  pg_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_reg[0][CFG_MON_BIT] && rail_sample_vld[0] &&
    volt_of(rail_volt, 0) < pg_off_reg[0] && volt_of(rail_volt, 0) <= pg_on_reg[0]
    |=> !power_good[0])
    else $error("power-good not cleared below off threshold");

  pg_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_reg[0][CFG_MON_BIT] && !fault_off[0] && (!rail_sample_vld[0] ||
    (volt_of(rail_volt, 0) <= pg_on_reg[0] && volt_of(rail_volt, 0) >= pg_off_reg[0]))
    |=> $stable(power_good[0]))
    else $error("power-good moved inside hysteresis band");

  pg_elig_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_reg[1][CFG_MON_BIT] && on_eligible[1] && !fault_off[1] |=> power_good[1])
    else $error("eligible rail not power-good");

  pg_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_off[1] |=> !power_good[1])
    else $error("fault shutdown kept power-good");

  uv_supp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    uv_event[1] |-> $past(seek_on[1]) && $past(seen_pg_reg[1]))
    else $error("under-voltage passed while off or before first good");

  flt_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    input_fault |-> $past(|(in_fault_en_reg & input_asserted)))
    else $error("fault without a prior asserted fault input");

  margin_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    men_next && margin_en_reg[0]
    |=> margin_state[1:0] == ($past(mlow_next) ? MARGIN_LOW : MARGIN_HIGH))
    else $error("enabled rail not margined to the selected side");
endmodule

/* File: testbench/rpg_rail_model.sv */
/*
  model of the monitored rails: presents the bench's rail levels as adc
  samples with a strobe every other cycle; between strobes the sample bus
  carries the inverse level, so only strobed samples may count.
  assumes bench levels change synchronously to mclk.
*/
`timescale 1ns/100ps
module rpg_rail_model
  import rpg_pkg::*;
(
  input  wire logic                                         mclk,            // system clock
  input  wire logic                                         rst_n,           // sync reset, active low
  input  wire logic [rpg_pkg::NUM_RAILS*rpg_pkg::ADC_W-1:0] volt_set,        // bench rail levels
  output logic      [rpg_pkg::NUM_RAILS*rpg_pkg::ADC_W-1:0] rail_volt,       // sample bus
  output logic      [rpg_pkg::NUM_RAILS-1:0]                rail_sample_vld  // sample strobe
);
  logic phase_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_reg <= 1'b0;
      rail_volt <= '0;
      rail_sample_vld <= '0;
    end else begin
      phase_reg <= ~phase_reg;
      rail_volt <= phase_reg ? volt_set : ~volt_set;
      rail_sample_vld <= {NUM_RAILS{phase_reg}};
    end
  end
endmodule

/* File: testbench/rpg_top_test.sv */
/*
  self-checking bench for rpg_top: apb tasks and scenario sequences.
  assumes rpg_pkg, rpg_top and rpg_rail_model are compiled first.
*/
`timescale 1ns/100ps
module rpg_top_test;
  import rpg_pkg::*;
  logic                       mclk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [11:0]                paddr = 12'h000;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [31:0]                pwdata = 32'h0;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [NUM_INPUTS-1:0]      gpio_in = '0;
  logic [NUM_RAILS*ADC_W-1:0] volt_set = '0;
  logic [NUM_RAILS*ADC_W-1:0] rail_volt;
  logic [NUM_RAILS-1:0]       rail_sample_vld;
  logic [NUM_RAILS-1:0]       on_eligible = '0;
  logic [NUM_RAILS-1:0]       off_eligible = '0;
  logic [NUM_RAILS-1:0]       fault_off = '0;
  logic [NUM_RAILS-1:0]       uv_raw = '0;
  logic                       control_line = 1'b0;
  logic [NUM_RAILS-1:0]       power_good;
  logic [NUM_RAILS-1:0]       uv_event;
  logic [NUM_RAILS-1:0]       seek_on;
  logic [NUM_INPUTS-1:0]      input_asserted;
  logic [2:0]                 state_select;
  logic                       input_fault;
  logic                       latch_clear;
  logic [NUM_RAILS*2-1:0]     margin_state;
  logic [31:0]                rdv;
  logic                       erv;
  int                         err_count = 0;
  int                         checked = 0;
  logic [11:0]                v0 [7] = '{12'h800, 12'h801, 12'h600, 12'h400, 12'h3ff, 12'h600, 12'h801};
  logic [6:0]                 p0 = 7'h4e;
  logic [3:0]                 ms [8] = '{4'h4, 4'h4, 4'h8, 4'h8, 4'hc, 4'hc, 4'hc, 4'h0};
  logic [7:0]                 mc = 8'h66;
  logic [7:0]                 mo = 8'h38;
  logic [7:0]                 me = 8'haa;

  initial begin
    forever #5 mclk = ~mclk;
  end

  rpg_rail_model rail_model (.mclk(mclk), .rst_n(rst_n), .volt_set(volt_set), .rail_volt(rail_volt),
                             .rail_sample_vld(rail_sample_vld));

  rpg_top DUT (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
               .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
               .rail_volt(rail_volt), .rail_sample_vld(rail_sample_vld), .on_eligible(on_eligible),
               .off_eligible(off_eligible), .fault_off(fault_off), .control_line(control_line),
               .uv_raw(uv_raw), .power_good(power_good), .uv_event(uv_event), .seek_on(seek_on),
               .input_asserted(input_asserted), .state_select(state_select), .input_fault(input_fault),
               .latch_clear(latch_clear), .margin_state(margin_state));

  task automatic end_sim;
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, erv);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv, erv);
    chk(rdv, exp);
  endtask

  // covers the model's strobe spacing plus the pg, vin-low and under-voltage stages
  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask

  task automatic pins(input logic [NUM_INPUTS-1:0] g);
    gpio_in <= g;
    settle();
  endtask

  task automatic wait_fault;
    int n;
    n = 0;
    while (input_fault !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(input_fault), 32'h1);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    chk(32'(power_good), 32'h0);
    rd(OFS_PG_ON_THR, 32'h0000_0fff);
    apb(1'b0, 12'h03c, 32'h0, rdv, erv);
    chk(32'(erv), 32'h1);
    wr(OFS_PG_ON_THR, 32'h800);
    wr(OFS_PG_OFF_THR, 32'h400);
    wr(OFS_RAIL_CFG, 32'h3);
    for (int i = 0; i < 7; i++) begin
      volt_set[11:0] <= v0[i];
      settle();
      chk(32'(power_good[0]), 32'(p0[i]));
    end
    uv_raw[1] <= 1'b1;
    settle();
    chk(32'(uv_event[1:0]), 32'h0);
    on_eligible[1] <= 1'b1;
    settle();
    chk(32'({uv_event[1:0], power_good[1:0]}), 32'hb);
    rd(OFS_PG_STAT, 32'h3);
    rd(OFS_UV_MASK, 32'h3);
    volt_set[11:0] <= 12'h3ff;
    settle();
    chk(32'(uv_event[1]), 32'h0);
    volt_set[11:0] <= 12'h801;
    on_eligible[1] <= 1'b0;
    off_eligible[1] <= 1'b1;
    settle();
    chk(32'(power_good[1:0]), 32'h1);
    off_eligible[1] <= 1'b0;
    on_eligible[1] <= 1'b1;
    fault_off[1] <= 1'b1;
    settle();
    chk(32'(power_good[1]), 32'h0);
    fault_off[1] <= 1'b0;
    wr(OFS_RAIL_SEL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_RAIL_CFG, {28'h0, ms[i]});
      wr(OFS_OPER, {30'h0, mo[i], 1'b0});
      control_line <= mc[i];
      settle();
      chk(32'({uv_event[1], seek_on[1]}), {30'h0, {2{me[i]}}});
    end
    wr(OFS_IN_EN, 32'h00ff_ffff);
    wr(OFS_IN_POL, 32'h2);
    wr(OFS_IN_FAULT_EN, 32'h8);
    wr(OFS_IN_CLR_EN, 32'h10);
    pins(24'h00_0000);
    chk({latch_clear, 4'h0, state_select, input_asserted}, 32'h0200_0002);
    pins(24'h80_001d);
    chk({latch_clear, 4'h0, state_select, input_asserted}, 32'h8780_001f);
    rd(OFS_IN_STAT, 32'h0080_001f);
    gpio_in <= 24'h80_0015;
    wait_fault();
    wr(OFS_MARGIN_SRC, 32'h2625);
    wr(OFS_MARGIN_EN, 32'h1);
    pins(24'h00_0060);
    chk(32'(margin_state[3:0]), {30'h0, MARGIN_LOW});
    pins(24'h00_0020);
    chk(32'(margin_state[3:0]), {30'h0, MARGIN_HIGH});
    pins(24'h00_0040);
    chk(32'(margin_state[3:0]), {30'h0, MARGIN_NONE});
    wr(OFS_MARGIN_SRC, 32'h2627);
    apb(1'b0, OFS_MISC_STAT, 32'h0, rdv, erv);
    chk(rdv & 32'h2, 32'h2);
    end_sim();
  end
endmodule
